// File: shared/wfd_pkg.sv
// Purpose: constants, types and CRC helper for the wake frame detector
// Assumes: APB word registers, one received byte per rx_valid_i
// Notes:   register offsets are word indexes, byte address bits 7:2
// How it works
// - command bit 3 picks multicast (1) or unicast (0); bits 2:1 reserved
// - a filter with command bit 0 clear never reports a match
// - 8-bit pattern offset, offset 0 is first destination address byte
// - CRC-16 over masked bytes compared with stored value means wake frame
// - sync detect enable suppresses normal reception
// - detection raises irq or power event, chosen by a control bit
// - a valid sync packet sets the sync received flag
// - clearing sync detect enable restores normal reception if pattern wake enable is clear and light sleep is low
// - sync check takes own, broadcast or multicast destination frames
// - after both address fields, search for six FF bytes
// - then node address must repeat sixteen times back to back
// - a broken repetition restarts the search for the FF run
// - the FF run and repetitions may sit anywhere after the addresses
// - light sleep forces both detectors on; full power obeys enables
// - 31-bit byte mask, bit j adds byte offset+j; mask bit 31 reads 0
// - four filters; enabled filter passing address and CRC means wake
// - pattern wake enable suppresses reception; a match sets its flag
package wfd_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [5:0] WFD_IDX_CTRL    = 6'h00;
  localparam logic [5:0] WFD_IDX_NODE_LO = 6'h01;
  localparam logic [5:0] WFD_IDX_NODE_HI = 6'h02;
  localparam logic [5:0] WFD_IDX_TBL     = 6'h04; // 8 table words
  localparam logic [2:0] WFD_TBL_CMD     = 3'h4;
  localparam int         WFD_TBL_WORDS   = 8;
  localparam int WFD_B_WAKE_EN  = 0;
  localparam int WFD_B_SYNC_EN  = 1;
  localparam int WFD_B_NOTIFY   = 2;
  localparam int WFD_B_WAKE_FLG = 4;
  localparam int WFD_B_SYNC_FLG = 5;
  localparam logic [31:0] WFD_MASK_WMASK = 32'h7FFFFFFF;
  localparam logic [31:0] WFD_CMD_WMASK  = 32'h09090909;
  localparam logic [31:0] WFD_RST_WORD   = 32'h00000000;
  // ----------------------------------------------------------------
  // frame and filter figures
  // ----------------------------------------------------------------
  localparam int         WFD_FILTERS   = 4;
  localparam int         WFD_CMD_MCAST = 3;
  localparam int         WFD_CMD_EN    = 0;
  localparam logic [8:0] WFD_ADDR_END  = 9'h00C; // after DA and SA
  localparam logic [8:0] WFD_MASK_LEN  = 9'h01F;
  localparam logic [8:0] WFD_POS_MAX   = 9'h1FF;
  localparam logic [7:0] WFD_FF        = 8'hFF;
  localparam logic [2:0] WFD_RUN_LEN   = 3'h6;
  localparam logic [2:0] WFD_LAST_BYTE = 3'h5;
  localparam logic [3:0] WFD_LAST_REP  = 4'hF;
  localparam logic [15:0] WFD_CRC_POLY = 16'hA001;
  localparam logic [15:0] WFD_CRC_INIT = 16'h0000;

  typedef enum logic [0:0] {
    WFD_SEARCH = 1'b0,
    WFD_REPS   = 1'b1
  } wfd_sync_t;

  // one byte of the reflected CRC-16, lsb first
  function automatic logic [15:0] wfd_crc_byte(
    input logic [15:0] c,
    input logic [7:0]  d
  );
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) begin
      x = x[0] ? ((x >> 1) ^ WFD_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction
endpackage

// File: shared/wfd_mem_if.sv
// Purpose: carrier between register logic and filter table memory
// Assumes: one write port, one registered read port
// Notes:   words carries the whole table for the matchers
`timescale 1ns/1ps
`default_nettype none
interface wfd_mem_if;
  logic             wr_en;
  logic [2:0]       idx;
  logic [31:0]      wdata;
  logic [31:0]      rdata;
  logic [7:0][31:0] words;
  modport ctrl (output wr_en, idx, wdata, input rdata, words);
  modport mem  (input wr_en, idx, wdata, output rdata, words);
endinterface // wfd_mem_if
`default_nettype wire

// File: rtl/wfd_filter_mem.sv
// Purpose: eight-word filter table with registered read data
// Assumes: writer already cleared reserved bits
// Notes:   every word also leaves on a flop for the matchers
`timescale 1ns/1ps
`default_nettype none
module wfd_filter_mem
  import wfd_pkg::*;
(
  input  wire logic core_clk_i, // 10 MHz clock
  input  wire logic rst_i,      // sync reset, high
  input  wire logic ce_i,       // clock enable
  wfd_mem_if.mem    bus         // table port
);
  typedef struct packed {
    logic [7:0][31:0] words;
    logic [31:0]      rdata;
  } wfd_mem_t;
  wfd_mem_t mem_reg;
  wfd_mem_t mem_next;

  // ----------------------------------------------------------------
  // read data from a flop, holding the old word when the same cycle writes it
  // ----------------------------------------------------------------
  always_comb begin
    mem_next = mem_reg;
    if (bus.wr_en) begin
      mem_next.words[bus.idx] = bus.wdata;
    end
    mem_next.rdata = mem_reg.words[bus.idx];
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mem_reg <= '0;
    end else if (ce_i) begin
      mem_reg <= mem_next;
    end
  end

  assign bus.rdata = mem_reg.rdata;
  assign bus.words = mem_reg.words;
endmodule // wfd_filter_mem
`default_nettype wire

// File: rtl/wfd_top.sv
// Purpose: pattern filter and sync packet wake detection with APB regs
// Assumes: rx bytes in wire order, frame FCS bytes may follow payload
// Notes:   one wait state on every APB access
`timescale 1ns/1ps
`default_nettype none
module wfd_top
  import wfd_pkg::*;
(
  input  wire logic        core_clk_i,    // 10 MHz clock
  input  wire logic        rst_i,         // sync reset, high
  input  wire logic        ce_i,          // freezes state when low
  input  wire logic        psel_i,        // apb select
  input  wire logic        penable_i,     // apb access phase
  input  wire logic        pwrite_i,      // apb direction
  input  wire logic [7:0]  paddr_i,       // apb byte address
  input  wire logic [31:0] pwdata_i,      // apb write data
  output logic      [31:0] prdata_o,      // apb read data
  output logic             pready_o,      // apb ready
  output logic             pslverr_o,     // unmapped address
  input  wire logic        rx_valid_i,    // rx byte strobe
  input  wire logic [7:0]  rx_data_i,     // rx byte
  input  wire logic        rx_sof_i,      // first byte of frame
  input  wire logic        rx_eof_i,      // last byte of frame
  input  wire logic        light_sleep_i, // light sleep power state
  output logic             rx_pass_o,     // normal reception allowed
  output logic             irq_o,         // host interrupt
  output logic             power_event_o  // power event output
);
  import wfd_pkg::*;

  typedef struct packed {
    logic                  wake_en;
    logic                  sync_en;
    logic                  notify_sel;
    logic                  wake_flag;
    logic                  sync_flag;
    logic [47:0]           node;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  rx_pass;
    logic                  irq;
    logic                  power_event_output;
    logic [8:0]            pos;
    logic                  da_node;
    logic                  da_bcast;
    logic                  mcast;
    logic [3:0][15:0]      crc;
    wfd_sync_t             sst;
    logic [2:0]            ff_cnt;
    logic [2:0]            abyte;
    logic [3:0]            reps;
    logic                  found;
  } wfd_state_t;

  wfd_state_t r_reg;
  wfd_state_t r_next;
  wfd_mem_if  tbl ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [5:0] widx;
  logic [5:0] tbl_off;
  logic       hit_tbl;
  logic       hit;
  logic       acc;
  logic       done;
  assign widx    = paddr_i[7:2];
  // table spans eight words from its base, entry index counts from zero there
  assign tbl_off = widx - WFD_IDX_TBL;
  assign hit_tbl = (widx >= WFD_IDX_TBL) && (widx < WFD_IDX_TBL + 6'(WFD_TBL_WORDS));
  assign hit     = hit_tbl || (widx == WFD_IDX_CTRL)
                   || (widx == WFD_IDX_NODE_LO)
                   || (widx == WFD_IDX_NODE_HI);
  assign acc     = psel_i && penable_i;
  assign done    = acc && r_reg.pready;

  // table writes clear reserved bits on the way in
  assign tbl.idx   = tbl_off[2:0];
  assign tbl.wr_en = ce_i && done && pwrite_i && hit_tbl;
  assign tbl.wdata = pwdata_i & ((tbl_off[2:0] < WFD_TBL_CMD) ? WFD_MASK_WMASK
                     : (tbl_off[2:0] == WFD_TBL_CMD) ? WFD_CMD_WMASK
                     : 32'hFFFFFFFF);

  wfd_filter_mem u_mem (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .bus        (tbl)
  );

  // ----------------------------------------------------------------
  // frame base values, cleared on the first byte
  // ----------------------------------------------------------------
  logic [8:0]       pos_b;
  logic [3:0][15:0] crc_b;
  logic [3:0][15:0] crc_u;
  logic [3:0]       fmatch;
  logic             sync_act;
  logic             pat_act;
  assign pos_b    = rx_sof_i ? 9'h000 : r_reg.pos;
  assign sync_act = r_reg.sync_en || light_sleep_i;
  assign pat_act  = r_reg.wake_en || light_sleep_i;

  // one matcher per filter
  for (genvar i = 0; i < WFD_FILTERS; i++) begin : g_flt
    logic [30:0] mask;
    logic [7:0]  off;
    logic [3:0]  cmd;
    logic [15:0] expc;
    logic [8:0]  rel;
    logic        take;
    assign mask  = tbl.words[i][30:0];
    assign off   = tbl.words[WFD_TBL_CMD + 1][8*i +: 8];
    assign cmd   = tbl.words[WFD_TBL_CMD][8*i +: 4];
    assign expc  = tbl.words[WFD_TBL_CMD + 2 + i/2][16*(i%2) +: 16];
    assign rel   = pos_b - {1'b0, off};
    assign take  = (pos_b >= {1'b0, off}) && (rel < WFD_MASK_LEN)
                   && mask[rel[4:0]];
    assign crc_b[i] = rx_sof_i ? WFD_CRC_INIT : r_reg.crc[i];
    assign crc_u[i] = take ? wfd_crc_byte(crc_b[i], rx_data_i)
                           : crc_b[i];
    // enable then address type then CRC compare
    assign fmatch[i] = cmd[WFD_CMD_EN]
                       && (cmd[WFD_CMD_MCAST] == r_reg.mcast)
                       && (r_reg.mcast || r_reg.da_node)
                       && (crc_u[i] == expc);
  end

  // node address byte in wire order
  function automatic logic [7:0] node_byte(
    input logic [47:0] a,
    input logic [2:0]  k
  );
    case (k)
      3'h0: node_byte = a[7:0];
      3'h1: node_byte = a[15:8];
      3'h2: node_byte = a[23:16];
      3'h3: node_byte = a[31:24];
      3'h4: node_byte = a[39:32];
      3'h5: node_byte = a[47:40];
      default: node_byte = 8'h00;
    endcase
  endfunction

  // read mux, table data already registered in the memory
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_tbl) begin
      rd_mux = tbl.rdata;
    end else if (widx == WFD_IDX_CTRL) begin
      rd_mux[WFD_B_WAKE_EN]  = r_reg.wake_en;
      rd_mux[WFD_B_SYNC_EN]  = r_reg.sync_en;
      rd_mux[WFD_B_NOTIFY]   = r_reg.notify_sel;
      rd_mux[WFD_B_WAKE_FLG] = r_reg.wake_flag;
      rd_mux[WFD_B_SYNC_FLG] = r_reg.sync_flag;
    end else if (widx == WFD_IDX_NODE_LO) begin
      rd_mux = r_reg.node[31:0];
    end else if (widx == WFD_IDX_NODE_HI) begin
      rd_mux = {16'h0000, r_reg.node[47:32]};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic sync_hit;
  logic pat_hit;
  logic wr_ctrl;
  always_comb begin
    r_next   = r_reg;
    sync_hit = 1'b0;
    pat_hit  = 1'b0;
    wr_ctrl  = done && pwrite_i && (widx == WFD_IDX_CTRL);
    // apb: answer one cycle into the access phase
    r_next.pready  = acc && !r_reg.pready;
    r_next.pslverr = acc && !r_reg.pready && !hit;
    if (acc && !r_reg.pready) begin
      r_next.prdata = hit ? rd_mux : 32'h00000000;
    end
    if (wr_ctrl) begin
      r_next.wake_en    = pwdata_i[WFD_B_WAKE_EN];
      r_next.sync_en    = pwdata_i[WFD_B_SYNC_EN];
      r_next.notify_sel = pwdata_i[WFD_B_NOTIFY];
      // flags are write one to clear
      r_next.wake_flag  = r_reg.wake_flag && !pwdata_i[WFD_B_WAKE_FLG];
      r_next.sync_flag  = r_reg.sync_flag && !pwdata_i[WFD_B_SYNC_FLG];
    end
    if (done && pwrite_i && (widx == WFD_IDX_NODE_LO)) begin
      r_next.node[31:0] = pwdata_i;
    end
    if (done && pwrite_i && (widx == WFD_IDX_NODE_HI)) begin
      r_next.node[47:32] = pwdata_i[15:0];
    end
    // receive byte
    if (rx_valid_i) begin
      if (rx_sof_i) begin
        r_next.da_node  = 1'b1;
        r_next.da_bcast = 1'b1;
        r_next.sst      = WFD_SEARCH;
        r_next.ff_cnt   = 3'h0;
        r_next.found    = 1'b0;
      end
      r_next.pos = (pos_b == WFD_POS_MAX) ? pos_b : pos_b + 9'h001;
      r_next.crc = crc_u;
      // destination address classes
      if (pos_b < 9'h006) begin
        if (rx_data_i != node_byte(r_reg.node, pos_b[2:0])) begin
          r_next.da_node = 1'b0;
        end
        if (rx_data_i != WFD_FF) begin
          r_next.da_bcast = 1'b0;
        end
      end
      if (pos_b == 9'h000) begin
        r_next.mcast = rx_data_i[0];
      end
      // sync run then sixteen repetitions, anywhere past the addresses
      if ((pos_b >= WFD_ADDR_END) && !r_next.found) begin
        case (r_next.sst)
          WFD_SEARCH: begin
            if (rx_data_i == WFD_FF) begin
              r_next.ff_cnt = (r_next.ff_cnt == WFD_RUN_LEN) ? WFD_RUN_LEN
                              : r_next.ff_cnt + 3'h1;
            end else if ((r_next.ff_cnt == WFD_RUN_LEN)
                         && (rx_data_i == node_byte(r_reg.node, 3'h0))) begin
              r_next.sst   = WFD_REPS;
              r_next.abyte = 3'h1;
              r_next.reps  = 4'h0;
            end else begin
              r_next.ff_cnt = 3'h0;
            end
          end
          WFD_REPS: begin
            if (rx_data_i == node_byte(r_reg.node, r_reg.abyte)) begin
              if (r_reg.abyte == WFD_LAST_BYTE) begin
                r_next.abyte = 3'h0;
                r_next.reps  = r_reg.reps + 4'h1;
                if (r_reg.reps == WFD_LAST_REP) begin
                  r_next.found = 1'b1;
                  r_next.sst   = WFD_SEARCH;
                end
              end else begin
                r_next.abyte = r_reg.abyte + 3'h1;
              end
            end else begin
              // broken run, this byte may start a new FF run
              r_next.sst    = WFD_SEARCH;
              r_next.ff_cnt = (rx_data_i == WFD_FF) ? 3'h1 : 3'h0;
            end
          end
          default: r_next.sst = WFD_SEARCH;
        endcase
      end
      if (rx_eof_i) begin
        sync_hit = sync_act && r_next.found
                   && (r_reg.da_node || r_reg.da_bcast || r_reg.mcast);
        pat_hit  = pat_act && (|fmatch);
      end
    end
    // set wins over a clear in the same cycle
    if (sync_hit) begin
      r_next.sync_flag = 1'b1;
    end
    if (pat_hit) begin
      r_next.wake_flag = 1'b1;
    end
    r_next.rx_pass = !(r_next.wake_en || r_next.sync_en
                       || light_sleep_i);
    r_next.irq = !r_next.notify_sel
                 && (r_next.wake_flag || r_next.sync_flag);
    r_next.power_event_output = r_next.notify_sel
                 && (r_next.wake_flag || r_next.sync_flag);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_reg         <= '0;
      r_reg.rx_pass <= 1'b1;
      r_reg.sst     <= WFD_SEARCH;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign prdata_o      = r_reg.prdata;
  assign pready_o      = r_reg.pready;
  assign pslverr_o     = r_reg.pslverr;
  assign rx_pass_o     = r_reg.rx_pass;
  assign irq_o         = r_reg.irq;
  assign power_event_o = r_reg.power_event_output;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_mask_top_zero: assert property (
    !tbl.words[0][31] && !tbl.words[1][31] && !tbl.words[2][31]
    && !tbl.words[3][31]) else $error("mask bit 31 not zero");
  a_cmd_reserved: assert property (
    (tbl.words[WFD_TBL_CMD] & ~WFD_CMD_WMASK) == 32'h00000000)
    else $error("command reserved bits set");
  a_off_filter_quiet: assert property (
    fmatch[0] |-> tbl.words[WFD_TBL_CMD][WFD_CMD_EN])
    else $error("disabled filter matched");
  a_pattern_flag: assert property (
    ce_i && pat_hit |=> r_reg.wake_flag && !rx_pass_o || light_sleep_i)
    else $error("pattern hit lost");
  a_sync_flag_set: assert property (
    ce_i && sync_hit |=> r_reg.sync_flag)
    else $error("sync hit lost");
  a_sync_needs_reps: assert property (
    $rose(r_reg.found) |-> $past(r_reg.sst) == WFD_REPS
    && $past(r_reg.reps) == WFD_LAST_REP)
    else $error("sync found early");
  a_rx_suppress: assert property (
    ce_i && r_next.sync_en |=> !rx_pass_o)
    else $error("reception not suppressed");
  a_notify_route: assert property (
    ce_i && (r_next.wake_flag || r_next.sync_flag) |=>
    (irq_o != power_event_o) && (power_event_o == r_reg.notify_sel))
    else $error("notify misrouted");
  a_apb_wait: assert property (
    ce_i && acc && !pready_o |=> pready_o ##1 !pready_o || !ce_i)
    else $error("apb answer late");
  c_sync_seen: cover property ($rose(r_reg.sync_flag));
  c_wake_seen: cover property ($rose(r_reg.wake_flag));
  c_sleep_hit: cover property (light_sleep_i && sync_hit);
endmodule // wfd_top
`default_nettype wire

// File: bench/wfd_rx_src.sv
// Purpose: receive datapath model that feeds frame bytes to the detector
// Assumes: one byte per clock inside a frame, no gaps between bytes
// Notes:   after a frame the data line shows the inverse of its last byte
`timescale 1ns/1ps
`default_nettype none
module wfd_rx_src (
  input  wire logic       core_clk_i, // bench clock
  output logic            rx_valid_o, // byte strobe
  output logic      [7:0] rx_data_o,  // received byte
  output logic            rx_sof_o,   // first byte of frame
  output logic            rx_eof_o    // last byte of frame
);
  // ----------------------------------------------------------------
  // idle line at time zero
  // ----------------------------------------------------------------
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h5A;
    rx_sof_o   = 1'b0;
    rx_eof_o   = 1'b0;
  end

  // ----------------------------------------------------------------
  // whole frame, back to back bytes
  // ----------------------------------------------------------------
  // released data is inverted so a stale byte can never pass for a fresh one
  task automatic send(input logic [7:0] fr[$]);
    for (int i = 0; i < fr.size(); i++) begin
      @(posedge core_clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= fr[i];
      rx_sof_o   <= (i == 0);
      rx_eof_o   <= (i == fr.size() - 1);
    end
    @(posedge core_clk_i);
    rx_valid_o <= 1'b0;
    rx_sof_o   <= 1'b0;
    rx_eof_o   <= 1'b0;
    rx_data_o  <= ~fr[fr.size() - 1];
  endtask
endmodule // wfd_rx_src
`default_nettype wire

// File: bench/wake_frame_detector_test.sv
// Purpose: self-checking bench for the wake frame detector
// Assumes: one wait state apb slave, flags visible a few cycles after eof
// Notes:   clock enable is tied high; frames come from the rx model
`timescale 1ns/1ps
`default_nettype none
module wake_frame_detector_test;
  import wfd_pkg::*;
  localparam logic [47:0] NODE  = 48'hA54B3C2D1E02; // own address, unicast
  localparam logic [47:0] BCAST = 48'hFFFFFFFFFFFF; // broadcast
  localparam logic [47:0] OTHER = 48'h00000000AB04; // foreign unicast
  localparam logic [47:0] MCAST = 48'h0000005E0001; // multicast group
  localparam logic [47:0] SDA [5] = '{NODE, BCAST, NODE, MCAST, OTHER};
  localparam int          SN  [5] = '{16, 16, 15, 16, 16};
  localparam logic        SE  [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0]  PC  [4] = '{8'h01, 8'h00, 8'h09, 8'h09};
  localparam logic [47:0] PDA [4] = '{NODE, NODE, NODE, MCAST};
  localparam logic        PE  [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        rx_valid, rx_sof, rx_eof, sleep, rx_pass, irq, pev;
  logic [7:0]  paddr, rx_data;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] crc;
  logic [7:0]  fr[$];
  int          mismatches, cmp_count;

  wfd_top dut (.core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_sof_i(rx_sof), .rx_eof_i(rx_eof), .light_sleep_i(sleep),
    .rx_pass_o(rx_pass), .irq_o(irq), .power_event_o(pev));
  wfd_rx_src src (.core_clk_i(clk), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .rx_sof_o(rx_sof), .rx_eof_o(rx_eof));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // apb master, ready and data taken at the rising edge that ends access
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chkb("pready", 1'b1, pready);
    if (pready !== 1'b1) begin
      test_done();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // frame building and reference crc
  // ----------------------------------------------------------------
  // bitwise form on purpose, independent of the byte loop in the design
  function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int b = 0; b < 8; b++) begin
      x = (x[0] ^ d[b]) ? ((x >> 1) ^ 16'hA001) : (x >> 1);
    end
    return x;
  endfunction
  task automatic hdr(input logic [47:0] da);
    fr = {};
    for (int i = 0; i < 12; i++) begin
      fr.push_back(i < 6 ? da[8*i +: 8] : 8'h10 + 8'(i));
    end
    fr.push_back(8'h08);
    fr.push_back(8'h00);
  endtask
  task automatic reps(input int n);
    for (int i = 0; i < 6 + 6 * n; i++) begin
      fr.push_back(i < 6 ? 8'hFF : NODE[8*(i % 6) +: 8]);
    end
  endtask
  task automatic run();
    src.send(fr);
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (50000) @(posedge clk);
    chkb("watchdog", 1'b0, 1'b1);
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, sleep} = 2'b10;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mismatches, cmp_count} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chkb("rx_pass reset", 1'b1, rx_pass);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chkb("unmapped err", 1'b1, err);
    // table readback: reserved bits drop out
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    apb(1'b0, 8'h10, 32'h0);
    chk("mask", 32'h7FFFFFFF, rd);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    apb(1'b0, 8'h20, 32'h0);
    chk("commands", 32'h09090909, rd);
    apb(1'b1, 8'h24, 32'hC3B2A10E);
    apb(1'b0, 8'h24, 32'h0);
    chk("offsets", 32'hC3B2A10E, rd);
    apb(1'b1, 8'h04, NODE[31:0]);
    apb(1'b1, 8'h08, {16'h0000, NODE[47:32]});
    // sync packets: own, broadcast, short, multicast, foreign
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 8'h00, {29'h0, k[0], 2'b10});
      @(negedge clk);
      chkb("rx_pass sync", 1'b0, rx_pass);
      hdr(SDA[k]);
      if (k == 0) begin
        reps(3);
        fr.push_back(8'h77);
      end
      reps(SN[k]);
      fr.push_back(8'hC3);
      run();
      chkb("sync flag", SE[k], rd[5]);
      chkb("irq", SE[k] & ~k[0], irq);
      chkb("power event", SE[k] & k[0], pev);
      apb(1'b1, 8'h00, 32'h00000030);
      @(negedge clk);
      chkb("rx_pass restored", 1'b1, rx_pass);
    end
    // pattern filter 0: bytes 14 and 16
    crc = crc_ref(crc_ref(16'h0000, 8'h30), 8'h32);
    apb(1'b1, 8'h10, 32'h00000005);
    apb(1'b1, 8'h24, 32'h0000000E);
    apb(1'b1, 8'h28, {16'hBEEF, crc});
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h20, {24'h0, PC[k]});
      apb(1'b1, 8'h00, 32'h00000001);
      @(negedge clk);
      chkb("rx_pass wake", 1'b0, rx_pass);
      hdr(PDA[k]);
      for (int i = 0; i < 10; i++) begin
        fr.push_back(8'h30 + 8'(i));
      end
      run();
      chkb("wake flag", PE[k], rd[4]);
      chkb("irq wake", PE[k], irq);
      apb(1'b1, 8'h00, 32'h00000030);
    end
    // light sleep overrides cleared enables
    sleep <= 1'b1;
    hdr(NODE);
    reps(16);
    run();
    chkb("sleep sync flag", 1'b1, rd[5]);
    chkb("rx_pass sleep", 1'b0, rx_pass);
    @(posedge clk);
    sleep <= 1'b0;
    apb(1'b1, 8'h00, 32'h00000030);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl cleared", 32'h0, rd);
    test_done();
  end
endmodule // wake_frame_detector_test
`default_nettype wire
